// ### sim/sfsp_host.sv
// host side model: mode 0 frames on the link clock
`timescale 1ns/1ps
module sfsp_host (
    output logic link_sclk,
    output logic chip_sel_n,
    output logic serial_in,
    input wire logic serial_out
);
    initial begin
        link_sclk = 1'b0;
        chip_sel_n = 1'b1;
        serial_in = 1'b0;
    end

    // whole bytes, then cut_bits stray bits; rx keeps the last 8 bits seen
    task automatic xfer(input logic [7:0] tx[$], input int cut_bits, output logic [7:0] rx);
        logic [7:0] b;
        rx = 8'h00;
        #3 chip_sel_n = 1'b0;
        for (int k = 0; k < 8 * tx.size() + cut_bits; k++) begin
            b = (k / 8 < tx.size()) ? tx[k / 8] : 8'hA5;
            serial_in = b[7 - k % 8];
            #7.5 link_sclk = 1'b1;
            rx = {rx[6:0], serial_out};
            #7.5 link_sclk = 1'b0;
        end
        // clock stands still between frames; the data line stops showing the last bit
        #8 chip_sel_n = 1'b1;
        serial_in = ~serial_in;
        #40;
    endtask
endmodule

// ### sim/tb_top.sv
// self-checking bench for the flash command core
`timescale 1ns/1ps
module tb_top;
    localparam int PROG_N = 600;
    localparam int SWR_N = 400;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    logic link_sclk;
    logic chip_sel_n;
    logic serial_in;
    logic serial_out;
    logic serial_out_en;
    sfsp_pkg::sfsp_arr_wr_t arr_wr;
    sfsp_pkg::sfsp_stat_t status_out;
    sfsp_pkg::sfsp_arr_wr_t wr_q[$];
    int n_mismatch = 0;
    int checks_done = 0;
    logic [7:0] rx;
    int oe_cnt = 0;

    always #2 mclk = ~mclk;

    sfsp_core #(.PROG_CYCLES(PROG_N), .SWR_CYCLES(SWR_N), .MEM_SIZE(sfsp_pkg::MEM_BYTES)) u_dut (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .link_sclk(link_sclk),
        .chip_sel_n(chip_sel_n),
        .serial_in(serial_in),
        .serial_out(serial_out),
        .serial_out_en(serial_out_en),
        .arr_wr(arr_wr),
        .status_out(status_out)
    );

    sfsp_host u_host (
        .link_sclk(link_sclk),
        .chip_sel_n(chip_sel_n),
        .serial_in(serial_in),
        .serial_out(serial_out)
    );

    always @(negedge mclk) begin
        if (arr_wr.valid === 1'b1) begin
            wr_q.push_back(arr_wr);
        end
    end

    // output enable changes on falling link edges and clears when chip select rises, so rising edges see it settled
    always @(posedge link_sclk) begin
        if (serial_out_en === 1'b1) begin
            oe_cnt++;
        end
    end

    task automatic end_of_test();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_wr(input sfsp_pkg::sfsp_arr_wr_t got, input sfsp_pkg::sfsp_arr_wr_t exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: array write got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmd(input logic [7:0] op);
        u_host.xfer('{op}, 0, rx);
    endtask

    task automatic rd_sr(input logic [7:0] op, input logic [7:0] exp, input logic exp_oe);
        int n0;
        n0 = oe_cnt;
        u_host.xfer('{op, 8'h00}, 0, rx);
        chk8(rx, exp, "status read");
        chk8(8'(oe_cnt - n0), exp_oe ? 8'h08 : 8'h00, "output enable");
    endtask

    // bounded poll of the busy flag
    task automatic wait_idle();
        int i;
        for (i = 0; i < 4000 && status_out.sr1[0] !== 1'b0; i++) begin
            @(negedge mclk);
        end
        if (i == 4000) begin
            n_mismatch++;
            $display("wrong value at %0t: busy never cleared", $time);
            end_of_test();
        end
    endtask

    task automatic t_latch();
        chk8(status_out.sr1, 8'h00, "sr1 after reset");
        cmd(sfsp_pkg::OP_WREN);
        chk8(status_out.sr1, 8'h02, "latch set");
        rd_sr(sfsp_pkg::OP_RD_SR1, 8'h02, 1'b1);
        cmd(sfsp_pkg::OP_WRDI);
        chk8(status_out.sr1, 8'h00, "latch cleared");
        cmd(sfsp_pkg::OP_VWREN);
        chk8(status_out.sr1, 8'h00, "volatile arm");
        cmd(sfsp_pkg::OP_WRDI);
    endtask

    task automatic t_nvwrite();
        u_host.xfer('{sfsp_pkg::OP_WRSR1, 8'hFF}, 0, rx);
        chk8(status_out.sr1, 8'h00, "write without latch");
        cmd(sfsp_pkg::OP_WREN);
        u_host.xfer('{sfsp_pkg::OP_WRSR1, 8'hFF}, 3, rx);
        chk8(status_out.sr1, 8'h02, "cut frame");
        u_host.xfer('{sfsp_pkg::OP_WRSR1, 8'hFF}, 0, rx);
        chk8(status_out.sr1, 8'h03, "write busy");
        rd_sr(sfsp_pkg::OP_RD_SR1, 8'h03, 1'b1);
        wait_idle();
        chk8(status_out.sr1, 8'hFC, "sr1 written");
        chk8(status_out.sr2, 8'h00, "sr2 untouched");
    endtask

    task automatic t_locks();
        cmd(sfsp_pkg::OP_WREN);
        u_host.xfer('{sfsp_pkg::OP_WRSR2, 8'hFF}, 0, rx);
        wait_idle();
        rd_sr(sfsp_pkg::OP_RD_SR2, 8'h7F, 1'b1);
        cmd(sfsp_pkg::OP_WREN);
        u_host.xfer('{sfsp_pkg::OP_WRSR2, 8'h00}, 0, rx);
        wait_idle();
        chk8(status_out.sr2 & 8'h38, 8'h38, "locks kept");
        cmd(sfsp_pkg::OP_VWREN);
        u_host.xfer('{sfsp_pkg::OP_WRSR2, 8'h02}, 0, rx);
        chk8(status_out.sr1, 8'hFC, "volatile no busy");
        chk8(status_out.sr2 & 8'h7A, 8'h3A, "volatile sr2");
        cmd(sfsp_pkg::OP_VWREN);
        u_host.xfer('{sfsp_pkg::OP_WRSR3, 8'h7F}, 0, rx);
        rd_sr(sfsp_pkg::OP_RD_SR3, 8'h7F, 1'b1);
        cmd(sfsp_pkg::OP_VWREN);
        u_host.xfer('{sfsp_pkg::OP_WRSR1, 8'hFC, 8'h00, 8'h55}, 0, rx);
        chk8(status_out.sr2, 8'h38, "three byte sr2");
        chk8(status_out.sr3, 8'h55, "three byte sr3");
    endtask

    task automatic t_program();
        logic [7:0] idx[4] = '{8'h00, 8'h01, 8'hFE, 8'hFF};
        logic [7:0] dat[4] = '{8'hD2, 8'hD3, 8'hD0, 8'hD1};
        sfsp_pkg::sfsp_arr_wr_t exp;
        cmd(sfsp_pkg::OP_WREN);
        u_host.xfer('{sfsp_pkg::OP_PROG, 8'h01, 8'h23, 8'hFE, 8'h11}, 0, rx);
        chk8(status_out.sr1, 8'hFE, "protected page");
        cmd(sfsp_pkg::OP_WRDI);
        cmd(sfsp_pkg::OP_VWREN);
        u_host.xfer('{sfsp_pkg::OP_WRSR1, 8'h00}, 0, rx);
        chk8(status_out.sr1, 8'h00, "volatile sr1");
        u_host.xfer('{sfsp_pkg::OP_PROG, 8'h01, 8'h23, 8'hFE, 8'h11}, 0, rx);
        chk8(8'(wr_q.size()), 8'h00, "program without latch");
        cmd(sfsp_pkg::OP_WREN);
        u_host.xfer('{sfsp_pkg::OP_PROG, 8'h01, 8'h23, 8'hFE, 8'hD0, 8'hD1, 8'hD2, 8'hD3}, 0, rx);
        chk8(status_out.sr1, 8'h03, "program busy");
        rd_sr(sfsp_pkg::OP_RD_SR2, 8'h00, 1'b0);
        wait_idle();
        chk8(status_out.sr1, 8'h00, "program done");
        chk8(8'(wr_q.size()), 8'h04, "byte count");
        for (int i = 0; i < 4 && wr_q.size() == 4; i++) begin
            exp.valid = 1'b1;
            exp.addr = {16'h0123, idx[i]};
            exp.data = dat[i];
            chk_wr(wr_q[i], exp);
        end
    endtask

    // second power-up: volatile values and the latch go, non-volatile values come back
    task automatic t_reset();
        cmd(sfsp_pkg::OP_WREN);
        @(negedge mclk);
        sys_rst = 1'b1;
        repeat (8) @(negedge mclk);
        sys_rst = 1'b0;
        repeat (4) @(negedge mclk);
        chk8(status_out.sr1, 8'hFC, "sr1 reloaded");
        chk8(status_out.sr2, 8'h38, "sr2 reloaded");
        chk8(status_out.sr3, 8'h00, "sr3 lost");
    endtask

    initial begin
        repeat (8) @(negedge mclk);
        sys_rst = 1'b0;
        repeat (4) @(negedge mclk);
        t_latch();
        t_nvwrite();
        t_locks();
        t_program();
        t_reset();
        end_of_test();
    end
endmodule

// ### src/sfsp_core.sv
// serial flash command core: status read/write, write enable control, page program
// Notes on behaviour
// - opcodes 05h, 35h, 15h return status register one, two, three respectively
// - opcode sampled on rising clock, status shifted out on falling, msb first
// - register one read is always accepted, also during a busy cycle
// - write-enable opcode framed by chip select sets the write enable latch
// - program and non-volatile status write refused while the latch is zero
// - volatile write-enable leaves the latch alone, arms volatile status write
// - write-disable opcode framed by chip select clears the write enable latch
// - latch clears at power-up and when a non-volatile status write or a program completes
// - only register one bits 7:2, two bits 6:0, three bits 6:0 change
// - security lock bits once set can never return to zero
// - status write discarded unless chip select rises on a byte boundary
// - non-volatile status write runs a timed busy cycle, then clears latch
// - volatile status write applies at once and busy stays zero
// - volatile status write keeps second protect bit and lock bits unchanged
// - power-up reloads registers one and two from the non-volatile copies; register three takes its reset value
// - register-one write with one data byte leaves register two unchanged
// - page program is opcode, 24-bit address, one or more data bytes
// - low address byte advances per data byte and wraps within the page
// - valid program runs a timed busy cycle, then clears the latch
// - program into a block-protected region is skipped
`timescale 1ns/1ps
module sfsp_core #(
    parameter int PROG_CYCLES = sfsp_pkg::PROG_CYC,
    parameter int SWR_CYCLES = sfsp_pkg::SWR_CYC,
    parameter int MEM_SIZE = sfsp_pkg::MEM_BYTES
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic link_sclk,
    input wire logic chip_sel_n,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_en,
    output sfsp_pkg::sfsp_arr_wr_t arr_wr,
    output sfsp_pkg::sfsp_stat_t status_out
);
    initial begin
        if (PROG_CYCLES <= sfsp_pkg::PAGE_BYTES + 1 || PROG_CYCLES >= (1 << sfsp_pkg::TMR_W))
            $error("PROG_CYCLES out of range");
        if (SWR_CYCLES < 4 || SWR_CYCLES >= (1 << sfsp_pkg::TMR_W))
            $error("SWR_CYCLES out of range");
        if (MEM_SIZE < sfsp_pkg::UNIT_LARGE || MEM_SIZE > (1 << 24))
            $error("MEM_SIZE out of range");
    end

    // ---------------- link domain (serial clock) ----------------
    logic [2:0] lk_bit_r;
    logic lk_op_done_r;
    logic lk_tgl_r;
    logic [7:0] lk_shift_r;
    logic [7:0] lk_opc_r;
    logic [7:0] lk_byte_r;
    logic lk_out_r;
    logic lk_oe_r;
    sfsp_pkg::sfsp_stat_t snap_r;

    wire [7:0] lk_shift_nxt = {lk_shift_r[6:0], serial_in};
    wire lk_byte_end = (lk_bit_r == 3'h7);

    // chip select high ends the frame asynchronously, since the serial clock stops between frames
    always_ff @(posedge link_sclk or posedge chip_sel_n) begin
        if (chip_sel_n) begin
            lk_bit_r <= 3'h0;
            lk_op_done_r <= 1'b0;
            lk_tgl_r <= 1'b0;
            lk_shift_r <= 8'h00;
            lk_opc_r <= 8'h00;
        end else begin
            lk_shift_r <= lk_shift_nxt;
            lk_bit_r <= lk_bit_r + 3'h1;
            lk_tgl_r <= ~lk_tgl_r;
            if (lk_byte_end) begin
                lk_op_done_r <= 1'b1;
            end
            if (lk_byte_end && !lk_op_done_r) begin
                lk_opc_r <= lk_shift_nxt;
            end
        end
    end

    // holds each completed byte for eight serial clocks; the core reads it after the bit toggle arrives
    always_ff @(posedge link_sclk) begin
        if (lk_byte_end) begin
            lk_byte_r <= lk_shift_nxt;
        end
    end

    // snapshot is frozen while chip select is low, so it is quasi-static to this domain
    wire lk_is_rd1 = (lk_opc_r == sfsp_pkg::OP_RD_SR1);
    wire lk_is_rd2 = (lk_opc_r == sfsp_pkg::OP_RD_SR2);
    wire lk_is_rd3 = (lk_opc_r == sfsp_pkg::OP_RD_SR3);
    wire lk_snap_busy = snap_r.sr1[sfsp_pkg::SR1_BUSY];
    wire lk_rd_ok = lk_op_done_r && (lk_is_rd1 || (!lk_snap_busy && (lk_is_rd2 || lk_is_rd3)));
    wire [7:0] lk_rd_byte = lk_is_rd1 ? snap_r.sr1 : (lk_is_rd2 ? snap_r.sr2 : snap_r.sr3);

    always_ff @(negedge link_sclk or posedge chip_sel_n) begin
        if (chip_sel_n) begin
            lk_out_r <= 1'b0;
            lk_oe_r <= 1'b0;
        end else begin
            lk_oe_r <= lk_rd_ok;
            lk_out_r <= lk_rd_ok & lk_rd_byte[~lk_bit_r];
        end
    end

    assign serial_out = lk_out_r;
    assign serial_out_en = lk_oe_r;

    // ---------------- core domain (mclk) ----------------
    logic cs_m1;
    logic cs_m2;
    logic cs_q;
    logic tg_m1;
    logic tg_m2;
    logic tg_q;
    logic [2:0] bits_r;
    logic [2:0] nb_r;
    logic [7:0] opc_r;
    logic [7:0] dat_r [3];
    logic [7:0] wptr_r;
    logic [7:0] pg_buf [sfsp_pkg::PAGE_BYTES];
    logic [sfsp_pkg::PAGE_BYTES-1:0] mask_r;
    logic wel_r;
    logic vol_arm_r;
    logic [7:0] sr1_r;
    logic [7:0] sr2_r;
    logic [7:0] sr3_r;
    // non-volatile copies are never reset: they carry their value across power-up
    logic [7:0] nv1_r = sfsp_pkg::SR1_RST & sfsp_pkg::SR1_WR_MASK;
    logic [7:0] nv2_r = sfsp_pkg::SR2_RST;
    logic [7:0] pend1_r;
    logic [7:0] pend2_r;
    logic [7:0] pend3_r;
    logic [2:0] pend_we_r;
    sfsp_pkg::sfsp_state_t state_r;
    logic [sfsp_pkg::TMR_W-1:0] tmr_r;
    logic [8:0] walk_r;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cs_m1 <= 1'b1;
            cs_m2 <= 1'b1;
            cs_q <= 1'b1;
            tg_m1 <= 1'b0;
            tg_m2 <= 1'b0;
            tg_q <= 1'b0;
        end else if (clk_en) begin
            cs_m1 <= chip_sel_n;
            cs_m2 <= cs_m1;
            cs_q <= cs_m2;
            tg_m1 <= lk_tgl_r;
            tg_m2 <= tg_m1;
            tg_q <= cs_m2 ? 1'b0 : tg_m2;
        end
    end

    // the toggle drops back to zero when the frame ends; that change is masked by the idle chip select
    wire idle_st = (state_r == sfsp_pkg::SFSP_IDLE);
    wire busy = !idle_st;
    wire frame_start = clk_en & ~cs_m2 & cs_q;
    wire frame_end = clk_en & cs_m2 & ~cs_q;
    wire bit_ev = clk_en & ~cs_m2 & (tg_m2 ^ tg_q);
    wire byte_ev = bit_ev & (bits_r == 3'h7);
    wire clean_end = frame_end & (bits_r == 3'h0) & idle_st;
    wire [23:0] addr = {dat_r[0], dat_r[1], dat_r[2]};
    wire data_ev = byte_ev & (nb_r >= 3'h4) & (opc_r == sfsp_pkg::OP_PROG) & idle_st;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            bits_r <= 3'h0;
            nb_r <= 3'h0;
            opc_r <= 8'h00;
            wptr_r <= 8'h00;
            dat_r <= '{3{8'h00}};
        end else if (clk_en) begin
            if (cs_m2) begin
                bits_r <= 3'h0;
                nb_r <= 3'h0;
            end else if (bit_ev) begin
                bits_r <= bits_r + 3'h1;
            end
            if (byte_ev && nb_r != 3'h7) begin
                nb_r <= nb_r + 3'h1;
            end
            // frames seen while busy are not captured, so the address under the program walk holds
            if (byte_ev && idle_st) begin
                if (nb_r == 3'h0) begin
                    opc_r <= lk_byte_r;
                end
                if (nb_r >= 3'h1 && nb_r <= 3'h3) begin
                    dat_r[2'(nb_r - 3'h1)] <= lk_byte_r;
                end
                if (nb_r == 3'h3) begin
                    wptr_r <= lk_byte_r;
                end else if (nb_r >= 3'h4) begin
                    wptr_r <= wptr_r + 8'h01;
                end
            end
        end
    end

    // page latch: later bytes at a wrapped index overwrite earlier ones
    always_ff @(posedge mclk) begin
        if (data_ev) begin
            pg_buf[wptr_r] <= lk_byte_r;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            mask_r <= '0;
        end else if (frame_start && idle_st) begin
            mask_r <= '0;
        end else if (data_ev) begin
            mask_r[wptr_r] <= 1'b1;
        end
    end

    // command decode at the end of a clean frame
    wire is_wrsr1 = (opc_r == sfsp_pkg::OP_WRSR1) && nb_r >= 3'h2 && nb_r <= 3'h4;
    wire is_wrsr2 = (opc_r == sfsp_pkg::OP_WRSR2) && nb_r >= 3'h2 && nb_r <= 3'h3;
    wire is_wrsr3 = (opc_r == sfsp_pkg::OP_WRSR3) && nb_r == 3'h2;
    wire cmd_wren = clean_end & (opc_r == sfsp_pkg::OP_WREN) & (nb_r == 3'h1);
    wire cmd_wrdi = clean_end & (opc_r == sfsp_pkg::OP_WRDI) & (nb_r == 3'h1);
    wire cmd_vwren = clean_end & (opc_r == sfsp_pkg::OP_VWREN) & (nb_r == 3'h1);
    wire cmd_wrsr = clean_end & (is_wrsr1 | is_wrsr2 | is_wrsr3) & (wel_r | vol_arm_r);
    wire wrsr_vol = vol_arm_r;
    wire cmd_wrsr_vol = cmd_wrsr & wrsr_vol;
    wire cmd_wrsr_nv = cmd_wrsr & ~wrsr_vol;

    // block protection decode from the live protect fields
    wire [2:0] bp = sr1_r[sfsp_pkg::SR1_BP_LO +: 3];
    wire [31:0] unit_sz = sr1_r[sfsp_pkg::SR1_SEC] ? 32'(sfsp_pkg::UNIT_SMALL) : 32'(sfsp_pkg::UNIT_LARGE);
    wire [31:0] lim_raw = unit_sz << (bp - 3'h1);
    wire [31:0] lim = (lim_raw > 32'(MEM_SIZE)) ? 32'(MEM_SIZE) : lim_raw;
    wire [31:0] addr32 = {8'h00, addr};
    wire in_range = sr1_r[sfsp_pkg::SR1_TB] ? (addr32 < lim) : (addr32 >= 32'(MEM_SIZE) - lim);
    wire prot_base = (bp == 3'h0) ? 1'b0 : ((bp == 3'h7) ? 1'b1 : in_range);
    wire prot_hit = prot_base ^ sr2_r[sfsp_pkg::SR2_CMP];
    wire cmd_prog = clean_end & (opc_r == sfsp_pkg::OP_PROG) & (nb_r >= 3'h5) & wel_r & ~prot_hit;

    // which registers a status write touches and with which byte
    wire we1 = is_wrsr1;
    wire we2 = (is_wrsr1 && nb_r >= 3'h3) || is_wrsr2;
    wire we3 = (is_wrsr1 && nb_r == 3'h4) || (is_wrsr2 && nb_r == 3'h3) || is_wrsr3;
    wire [7:0] v1 = dat_r[0];
    wire [7:0] v2 = is_wrsr2 ? dat_r[0] : dat_r[1];
    wire [7:0] v3 = is_wrsr3 ? dat_r[0] : (is_wrsr2 ? dat_r[1] : dat_r[2]);
    wire [7:0] n1 = (sr1_r & ~sfsp_pkg::SR1_WR_MASK) | (v1 & sfsp_pkg::SR1_WR_MASK);
    wire [7:0] n2_raw = (sr2_r & ~sfsp_pkg::SR2_WR_MASK) | (v2 & sfsp_pkg::SR2_WR_MASK);
    wire [7:0] n2_nv = n2_raw | (sr2_r & sfsp_pkg::SR2_LOCK_MASK);
    wire [7:0] n2_vol = (n2_raw & ~sfsp_pkg::SR2_OTP_MASK) | (sr2_r & sfsp_pkg::SR2_OTP_MASK);
    wire [7:0] n3 = (sr3_r & ~sfsp_pkg::SR3_WR_MASK) | (v3 & sfsp_pkg::SR3_WR_MASK);

    wire tmr_done = busy & (tmr_r == '0);
    wire swr_done = tmr_done & (state_r == sfsp_pkg::SFSP_SWR);

    sfsp_pkg::sfsp_state_t state_nxt;
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            sfsp_pkg::SFSP_IDLE: begin
                if (cmd_wrsr_nv) begin
                    state_nxt = sfsp_pkg::SFSP_SWR;
                end else if (cmd_prog) begin
                    state_nxt = sfsp_pkg::SFSP_PROG;
                end
            end
            sfsp_pkg::SFSP_SWR,
            sfsp_pkg::SFSP_PROG: begin
                if (tmr_done) begin
                    state_nxt = sfsp_pkg::SFSP_IDLE;
                end
            end
            default: state_nxt = sfsp_pkg::SFSP_IDLE;
        endcase
    end

    wire [sfsp_pkg::TMR_W-1:0] tmr_nxt = cmd_wrsr_nv ? sfsp_pkg::TMR_W'(SWR_CYCLES - 1) :
        (cmd_prog ? sfsp_pkg::TMR_W'(PROG_CYCLES - 1) : (busy ? tmr_r - 1'b1 : tmr_r));
    wire wel_nxt = tmr_done ? 1'b0 : (cmd_wren ? 1'b1 : (cmd_wrdi ? 1'b0 : wel_r));
    wire vol_nxt = cmd_vwren ? 1'b1 : ((cmd_wrsr | cmd_wren | cmd_wrdi | cmd_prog) ? 1'b0 : vol_arm_r);

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_r <= sfsp_pkg::SFSP_IDLE;
            tmr_r <= '0;
            wel_r <= 1'b0;
            vol_arm_r <= 1'b0;
        end else if (clk_en) begin
            state_r <= state_nxt;
            tmr_r <= tmr_nxt;
            wel_r <= wel_nxt;
            vol_arm_r <= vol_nxt;
        end
    end

    // live and non-volatile copies; reset stands for power-up
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sr1_r <= nv1_r;
            sr2_r <= nv2_r;
            sr3_r <= sfsp_pkg::SR3_RST;
            pend1_r <= 8'h00;
            pend2_r <= 8'h00;
            pend3_r <= 8'h00;
            pend_we_r <= 3'h0;
        end else if (clk_en) begin
            if (cmd_wrsr_vol) begin
                if (we1) sr1_r <= n1;
                if (we2) sr2_r <= n2_vol;
                if (we3) sr3_r <= n3;
            end
            if (cmd_wrsr_nv) begin
                pend1_r <= n1;
                pend2_r <= n2_nv;
                pend3_r <= n3;
                pend_we_r <= {we3, we2, we1};
            end
            if (swr_done) begin
                if (pend_we_r[0]) begin
                    sr1_r <= pend1_r;
                    nv1_r <= pend1_r;
                end
                if (pend_we_r[1]) begin
                    sr2_r <= pend2_r;
                    nv2_r <= pend2_r;
                end
                if (pend_we_r[2]) sr3_r <= pend3_r;
            end
        end
    end

    // program walk: hand latched bytes to the array at the start of the cycle
    wire walk_on = (state_r == sfsp_pkg::SFSP_PROG) & ~walk_r[8];
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            walk_r <= 9'h100;
            arr_wr <= '0;
        end else if (clk_en) begin
            walk_r <= cmd_prog ? 9'h000 : (walk_on ? walk_r + 9'h001 : walk_r);
            arr_wr.valid <= walk_on & mask_r[walk_r[7:0]];
            arr_wr.addr <= {addr[23:8], walk_r[7:0]};
            arr_wr.data <= pg_buf[walk_r[7:0]];
        end
    end

    // status views: snapshot only moves between frames
    wire [7:0] sr1_view = {sr1_r[7:2], wel_r, busy};
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            snap_r <= '0;
            status_out <= '0;
        end else if (clk_en) begin
            status_out <= '{sr3: sr3_r, sr2: sr2_r, sr1: sr1_view};
            if (cs_m2) begin
                snap_r <= '{sr3: sr3_r, sr2: sr2_r, sr1: sr1_view};
            end
        end
    end

    // ---------------- checks ----------------
    default clocking ck @(posedge mclk); endclocking
    default disable iff (sys_rst);

    a_wel_set: assert property (cmd_wren |=> wel_r) else $error("latch not set");
    a_wel_clr: assert property (cmd_wrdi |=> !wel_r) else $error("latch not cleared");
    a_vwren_keep: assert property (cmd_vwren |=> $stable(wel_r)) else $error("latch moved");
    a_refuse_prog: assert property (clean_end && !wel_r |=> !busy) else $error("refused command ran");
    a_nv_busy: assert property (cmd_wrsr_nv && clk_en |=> busy [*4]) else $error("no busy cycle");
    a_done_clr: assert property ($fell(busy) |-> !wel_r) else $error("latch after cycle");
    a_lock_sticky: assert property (clk_en |=> ($past(sr2_r) & sfsp_pkg::SR2_LOCK_MASK & ~sr2_r) == 8'h00)
        else $error("lock bit fell");
    a_ro_bits: assert property (sr2_r[7] == sfsp_pkg::SR2_RST[7] && sr3_r[7] == sfsp_pkg::SR3_RST[7])
        else $error("read-only bit moved");
    a_vol_nobusy: assert property (cmd_wrsr_vol |=> !busy [*4]) else $error("busy on volatile write");
    a_vol_otp: assert property (cmd_wrsr_vol |=> (sr2_r & sfsp_pkg::SR2_OTP_MASK) ==
        ($past(sr2_r) & sfsp_pkg::SR2_OTP_MASK)) else $error("otp bit moved");
    a_busy_ignore: assert property (busy && !tmr_done && frame_end |=> $stable(wel_r))
        else $error("command taken while busy");
    a_one_byte: assert property (cmd_wrsr_vol && is_wrsr1 && nb_r == 3'h2 |=> $stable(sr2_r))
        else $error("register two touched");

    c_prog: cover property (cmd_prog ##[1:300] arr_wr.valid);
    c_nv_write: cover property (cmd_wrsr_nv);
    c_vol_write: cover property (cmd_vwren ##[1:1000] cmd_wrsr_vol);
endmodule

// ### src/sfsp_pkg.sv
// shared constants and types for the serial flash status and page program block
package sfsp_pkg;
    // opcodes
    localparam logic [7:0] OP_RD_SR1 = 8'h05;
    localparam logic [7:0] OP_RD_SR2 = 8'h35;
    localparam logic [7:0] OP_RD_SR3 = 8'h15;
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_VWREN = 8'h50;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_WRSR1 = 8'h01;
    localparam logic [7:0] OP_WRSR2 = 8'h31;
    localparam logic [7:0] OP_WRSR3 = 8'h11;
    localparam logic [7:0] OP_PROG = 8'h02;
    // status register one fields
    localparam int SR1_BUSY = 0;
    localparam int SR1_WEL = 1;
    localparam int SR1_BP_LO = 2;
    localparam int SR1_TB = 5;
    localparam int SR1_SEC = 6;
    // status register two fields
    localparam int SR2_CMP = 6;
    // writable and one-time-programmable masks
    localparam logic [7:0] SR1_WR_MASK = 8'hFC;
    localparam logic [7:0] SR2_WR_MASK = 8'h7F;
    localparam logic [7:0] SR3_WR_MASK = 8'h7F;
    localparam logic [7:0] SR2_LOCK_MASK = 8'h38;
    localparam logic [7:0] SR2_OTP_MASK = 8'h39;
    // reset values of the stored status bits
    localparam logic [7:0] SR1_RST = 8'h00;
    localparam logic [7:0] SR2_RST = 8'h00;
    localparam logic [7:0] SR3_RST = 8'h00;
    // memory geometry
    localparam int PAGE_BYTES = 256;
    localparam int MEM_BYTES = 262144;
    localparam int UNIT_SMALL = 4096;
    localparam int UNIT_LARGE = 65536;
    // timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int PROGRAM_CYCLE_TIME_NS = 700000;
    localparam int STATUS_WRITE_TIME_NS = 5000000;
    localparam int PROG_CYC = PROGRAM_CYCLE_TIME_NS / CLK_PERIOD_NS;
    localparam int SWR_CYC = STATUS_WRITE_TIME_NS / CLK_PERIOD_NS;
    localparam int TMR_W = 24;

    typedef enum logic [2:0] {
        SFSP_IDLE = 3'b001,
        SFSP_SWR = 3'b010,
        SFSP_PROG = 3'b100
    } sfsp_state_t;

    typedef struct packed {
        logic valid;
        logic [23:0] addr;
        logic [7:0] data;
    } sfsp_arr_wr_t;

    typedef struct packed {
        logic [7:0] sr3;
        logic [7:0] sr2;
        logic [7:0] sr1;
    } sfsp_stat_t;
endpackage
